// file: hdl/cfg_pins.v
// Purpose: Config done flag, reconfiguration request and test access port
// Assumes: Test clock and pins sampled by clk_sys, test clock well below 10 MHz
// Notes: Config engine is external; this block only sequences the pins
`timescale 1ns/100ps
`include "cfg_pins_regs.vh"
module cfg_pins #(
  parameter RECONF_CYC = `RECONF_MIN_CYC,
  parameter USER_CYC = `USER_WAIT_CYC
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Config engine side
  input wire cfg_loaded,
  output reg reconfig_start,
  output reg user_mode,
  // Done pin
  input wire config_complete_flag_in,
  output reg config_complete_flag_out,
  output reg config_complete_flag_oe,
  // Reconfiguration request pin
  input wire reconfig_req_n,
  // Test port pins, tms and tdi undriven seen as one by pad pull-up
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdo_oe
);
  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  // Every pin passes two flops; idle levels are preset so that
  // no false edge or false request follows reset
  localparam SY_TCK = 0;
  localparam SY_TMS = 1;
  localparam SY_TDI = 2;
  localparam SY_REQ = 3;
  localparam SY_DONE = 4;
  localparam SY_N = 5;
  // Tck low, tms and tdi one by pull-up, request idle high, done low
  localparam [SY_N-1:0] SY_INIT = 5'h0E;
  wire [SY_N-1:0] pin_raw = {config_complete_flag_in, reconfig_req_n, tdi, tms, tck};
  wire [SY_N-1:0] pin_s;
  genvar g;
  generate
    for (g = 0; g < SY_N; g = g + 1) begin : g_sync
      reg meta_r;
      reg sync_r;
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          meta_r <= SY_INIT[g];
          sync_r <= SY_INIT[g];
        end else begin
          meta_r <= pin_raw[g];
          sync_r <= meta_r;
        end
      end
      assign pin_s[g] = sync_r;
    end
  endgenerate
  reg tck_d_r;
  reg req_d_r;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tck_d_r <= 1'b0;
      req_d_r <= 1'b1;
    end else begin
      tck_d_r <= pin_s[SY_TCK];
      req_d_r <= pin_s[SY_REQ];
    end
  end
  wire tck_v = pin_s[SY_TCK];
  wire req_v = pin_s[SY_REQ];
  wire done_v = pin_s[SY_DONE];
  wire tck_rise = tck_v & ~tck_d_r;
  wire tck_fall = ~tck_v & tck_d_r;

  // ----------------------------------------
  // Reconfiguration and done flag
  // ----------------------------------------
  // Only config sequencing is touched here; user logic has its own reset
  reg [15:0] low_cnt_r;
  reg [15:0] user_cnt_r;
  reg req_ok_r;
  wire req_rise = req_v & ~req_d_r;
  // Qualify the low pulse; anything shorter than RECONF_CYC is ignored
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      low_cnt_r <= 16'h0000;
      req_ok_r <= 1'b0;
    end else begin
      if (!req_v) begin
        if (low_cnt_r != 16'hFFFF)
          low_cnt_r <= low_cnt_r + 16'h0001;
        // Count stands at RECONF_CYC-1 on the last cycle of a minimum pulse
        if (low_cnt_r >= RECONF_CYC[15:0] - 16'h0001)
          req_ok_r <= 1'b1;
      end else begin
        low_cnt_r <= 16'h0000;
        req_ok_r <= 1'b0;
      end
    end
  end
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reconfig_start <= 1'b0;
      user_cnt_r <= 16'h0000;
      user_mode <= 1'b0;
      config_complete_flag_out <= 1'b0;
      config_complete_flag_oe <= 1'b1;
    end else begin
      reconfig_start <= 1'b0;
      if (req_rise && req_ok_r) begin
        reconfig_start <= 1'b1;
        user_mode <= 1'b0;
        user_cnt_r <= 16'h0000;
        config_complete_flag_oe <= 1'b1;
      end else begin
        // Release when loaded; pull-up gives the high level
        config_complete_flag_oe <= ~cfg_loaded;
        if (done_v && cfg_loaded) begin
          if (user_cnt_r >= USER_CYC[15:0])
            user_mode <= 1'b1;
          else
            user_cnt_r <= user_cnt_r + 16'h0001;
        end else begin
          user_cnt_r <= 16'h0000;
          user_mode <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Test access port
  // ----------------------------------------
  // Pins never muxed to user I/O; no path exists for that
  reg [3:0] st_r, st_nxt;
  reg [`IR_LEN-1:0] ir_r, ir_sh_r;
  reg [31:0] dr_sh_r;
  wire tms_v = pin_s[SY_TMS];
  wire tdi_v = pin_s[SY_TDI];
  always @* begin
    st_nxt = st_r;
    case (st_r)
      `ST_RESET: st_nxt = tms_v ? `ST_RESET : `ST_IDLE;
      `ST_IDLE: st_nxt = tms_v ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_DR: st_nxt = tms_v ? `ST_SEL_IR : `ST_CAP_DR;
      `ST_CAP_DR: st_nxt = tms_v ? `ST_EX1_DR : `ST_SH_DR;
      `ST_SH_DR: st_nxt = tms_v ? `ST_EX1_DR : `ST_SH_DR;
      `ST_EX1_DR: st_nxt = tms_v ? `ST_UP_DR : `ST_PA_DR;
      `ST_PA_DR: st_nxt = tms_v ? `ST_EX2_DR : `ST_PA_DR;
      `ST_EX2_DR: st_nxt = tms_v ? `ST_UP_DR : `ST_SH_DR;
      `ST_UP_DR: st_nxt = tms_v ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_IR: st_nxt = tms_v ? `ST_RESET : `ST_CAP_IR;
      `ST_CAP_IR: st_nxt = tms_v ? `ST_EX1_IR : `ST_SH_IR;
      `ST_SH_IR: st_nxt = tms_v ? `ST_EX1_IR : `ST_SH_IR;
      `ST_EX1_IR: st_nxt = tms_v ? `ST_UP_IR : `ST_PA_IR;
      `ST_PA_IR: st_nxt = tms_v ? `ST_EX2_IR : `ST_PA_IR;
      `ST_EX2_IR: st_nxt = tms_v ? `ST_UP_IR : `ST_SH_IR;
      `ST_UP_IR: st_nxt = tms_v ? `ST_SEL_DR : `ST_IDLE;
      default: st_nxt = `ST_RESET;
    endcase
  end
  wire bypass_sel = (ir_r != `IR_IDCODE);

  // Only the two shift states may drive tdo
  function in_shift;
    input [3:0] st;
    begin
      in_shift = (st == `ST_SH_DR) || (st == `ST_SH_IR);
    end
  endfunction
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= `ST_RESET;
      ir_r <= `IR_RESET;
      ir_sh_r <= {`IR_LEN{1'b0}};
      dr_sh_r <= 32'h00000000;
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      if (tck_rise) begin
        st_r <= st_nxt;
        case (st_r)
          `ST_RESET: ir_r <= `IR_IDCODE;
          `ST_CAP_IR: ir_sh_r <= `IR_RESET;
          `ST_SH_IR: ir_sh_r <= {tdi_v, ir_sh_r[`IR_LEN-1:1]};
          `ST_UP_IR: ir_r <= ir_sh_r;
          `ST_CAP_DR: dr_sh_r <= bypass_sel ? 32'h00000000 : `IDCODE_VAL;
          `ST_SH_DR: begin
            // Bypass is one bit long, idcode thirty-two
            if (bypass_sel)
              dr_sh_r[0] <= tdi_v;
            else
              dr_sh_r <= {tdi_v, dr_sh_r[31:1]};
          end
          default: ir_r <= ir_r;
        endcase
      end
      if (tck_fall) begin
        // Output moves only on falling edge
        tdo_oe <= in_shift(st_r);
        tdo <= (st_r == `ST_SH_IR) ? ir_sh_r[0] : dr_sh_r[0];
      end
    end
  end
endmodule

// file: hdl/cfg_pins_regs.vh
// Purpose: Constants for configuration status and test port pins
// Assumes: 40 MHz system clock
// Notes: Times in ns, counts derived here from the clock period
`ifndef CFG_PINS_REGS_VH
`define CFG_PINS_REGS_VH
`define CLK_PERIOD_NS 25
`define RECONF_MIN_NS 1000
`define RECONF_MIN_CYC ((`RECONF_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define USER_WAIT_NS 25000
`define USER_WAIT_CYC ((`USER_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IR_LEN 4
`define IR_RESET 4'h1
`define IR_BYPASS 4'hF
`define IR_IDCODE 4'h2
`define IDCODE_VAL 32'h00000001
`define ST_RESET 4'h0
`define ST_IDLE 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SH_DR 4'h4
`define ST_EX1_DR 4'h5
`define ST_PA_DR 4'h6
`define ST_EX2_DR 4'h7
`define ST_UP_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'hA
`define ST_SH_IR 4'hB
`define ST_EX1_IR 4'hC
`define ST_PA_IR 4'hD
`define ST_EX2_IR 4'hE
`define ST_UP_IR 4'hF
`endif

// file: dv/cfg_pins_monitor.sv
// Purpose: Assertions on the done, request and test port pins
// Assumes: USER_CYC handed on from the design instance
// Notes: Attached by bind below
`timescale 1ns/100ps
module cfg_pins_monitor #(parameter USER_CYC = 20) (
  // System
  input wire clk_sys,
  input wire rst,
  // Config pins
  input wire cfg_loaded,
  input wire reconfig_start,
  input wire user_mode,
  input wire config_complete_flag_in,
  input wire config_complete_flag_out,
  input wire config_complete_flag_oe,
  input wire reconfig_req_n,
  // Test port
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire tdo,
  input wire tdo_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ------
  // Checks
  // ------
  // Saturation not needed, only the rise of user mode is judged
  reg [15:0] hi_r;
  always @(posedge clk_sys or posedge rst)
    if (rst) hi_r <= 16'h0000;
    else hi_r <= config_complete_flag_in ? hi_r + 16'h0001 : 16'h0000;
  sequence s_pulse; reconfig_start ##1 !reconfig_start; endsequence
  property p_od; config_complete_flag_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("done pin driven high");
  property p_um; !config_complete_flag_in |-> ##[1:3] !user_mode; endproperty
  a_um: assert property (p_um) else $error("user mode with done low");
  property p_wait; $rose(user_mode) |-> hi_r >= USER_CYC; endproperty
  a_wait: assert property (p_wait) else $error("user mode too early");
  property p_one; reconfig_start |-> s_pulse; endproperty
  a_one: assert property (p_one) else $error("restart pulse too long");
  property p_oe; reconfig_start |-> ##[0:1] (config_complete_flag_oe && !user_mode); endproperty
  a_oe: assert property (p_oe) else $error("done not pulled on restart");
  property p_req; reconfig_start |-> reconfig_req_n && !$past(reconfig_req_n, 4); endproperty
  a_req: assert property (p_req) else $error("restart without request");
  property p_tdo; $changed(tdo) |-> !$past(tck, 2); endproperty
  a_tdo: assert property (p_tdo) else $error("tdo moved on rising side");
  property p_toe; $changed(tdo_oe) |-> !$past(tck, 2); endproperty
  a_toe: assert property (p_toe) else $error("tdo enable moved on rising side");
endmodule
bind cfg_pins cfg_pins_monitor #(.USER_CYC(USER_CYC)) mon (.clk_sys, .rst, .cfg_loaded, .reconfig_start,
  .user_mode, .config_complete_flag_in, .config_complete_flag_out, .config_complete_flag_oe,
  .reconfig_req_n, .tck, .tms, .tdi, .tdo, .tdo_oe);

// file: dv/scan_host.sv
// Purpose: Scan host and board model
// Assumes: 200 ns test clock made from clk_sys
// Notes: Test clock stands low between bits
`timescale 1ns/100ps
module scan_host (
  // Bench side
  input wire clk_sys,
  input wire hold_low,
  // Pins
  input wire flag_oe,
  input wire tdo,
  input wire tdo_oe,
  output logic done_line,
  output logic tck,
  output logic tms,
  output logic tdi
);
  // ----
  // Pins
  // ----
  assign done_line = !flag_oe && !hold_low;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // Released tdo reads inverted so a stale value never passes
  task automatic bit_io(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk_sys);
    tck = 1'b1;
    repeat (3) @(negedge clk_sys);
    q = tdo_oe ? tdo : !tdo;
    @(negedge clk_sys);
    tck = 1'b0;
  endtask
endmodule

// file: dv/cfg_pins_bench.sv
// Purpose: Self-checking bench for cfg_pins
// Assumes: Short counts set by parameters
// Notes: Scan data from xorshift seeded 95
`timescale 1ns/100ps
`include "cfg_pins_regs.vh"
module cfg_pins_bench;
  logic clk_sys, rst, cfg_loaded, reconfig_req_n, hold_low, q;
  wire flag_in, tck, tms, tdi, reconfig_start, user_mode, flag_out, flag_oe, tdo, tdo_oe;
  int error_cnt = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h0000005F;
  cfg_pins #(.RECONF_CYC(4), .USER_CYC(20)) dut (.clk_sys, .rst, .cfg_loaded, .reconfig_start,
    .user_mode, .config_complete_flag_in(flag_in), .config_complete_flag_out(flag_out),
    .config_complete_flag_oe(flag_oe), .reconfig_req_n, .tck, .tms, .tdi, .tdo, .tdo_oe);
  scan_host host (.clk_sys, .hold_low, .flag_oe, .tdo, .tdo_oe, .done_line(flag_in), .tck, .tms, .tdi);
  // -----
  // Tasks
  // -----
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic check(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic walk(input logic [7:0] seq, input int n);
    for (int i = 0; i < n; i++) host.bit_io(seq[i], 1'b1, q);
  endtask
  task automatic pulse(input int len, input logic exp);
    logic seen;
    seen = 1'b0;
    reconfig_req_n = 1'b0;
    repeat (len) @(negedge clk_sys);
    reconfig_req_n = 1'b1;
    repeat (8) begin
      @(negedge clk_sys);
      seen = seen | reconfig_start;
    end
    check("reconfig start", exp, seen);
  endtask
  // From idle: shift a code and check the IR capture, or 40 random bits expected back after dly
  task automatic scan(input logic ir, input logic [3:0] code, input int dly);
    logic [39:0] d;
    seed = xs(seed);
    d = ir ? {36'h0, code} : {seed[7:0], seed};
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int k = 0; k < (ir ? 4 : 40); k++) begin
      host.bit_io(k == (ir ? 3 : 39), d[k], q);
      if (ir) check("ir capture", 1'(`IR_RESET >> k), q);
      if (!ir && k >= dly) check("scan out", d[k - dly], q);
      if (!ir && k < dly && dly == 32) check("id code", 1'(`IDCODE_VAL >> k), q);
    end
    walk(8'h01, 2);
    repeat (6) @(negedge clk_sys);
    check("tdo enable", 1'b0, tdo_oe);
  endtask
  // --------
  // Sequence
  // --------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Tests need about 1000 cycles; 8000 allowed
  initial begin
    #200000;
    error_cnt++;
    stop_test;
  end
  initial begin
    rst = 1'b1;
    cfg_loaded = 1'b0;
    reconfig_req_n = 1'b1;
    hold_low = 1'b0;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    cfg_loaded = 1'b1;
    for (int i = 0; i < 40 && user_mode !== 1'b1; i++) @(negedge clk_sys);
    check("user mode", 1'b1, user_mode);
    hold_low = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("user mode held", 1'b0, user_mode);
    hold_low = 1'b0;
    $display("test done line finished");
    pulse(3, 1'b0);
    pulse(4, 1'b1);
    pulse(6, 1'b1);
    $display("test reconfig finished");
    walk(8'h1F, 6);
    scan(1'b1, `IR_IDCODE, 0);
    scan(1'b0, 4'h0, 32);
    scan(1'b1, `IR_BYPASS, 0);
    scan(1'b0, 4'h0, 1);
    $display("test scan finished");
    stop_test;
  end
endmodule
